// File: design/bspl_pkg.sv
// package for the battery status pin logic: register map, field
// layouts, reset values, timing constants and the controller states.
// assumes a single 25 MHz clock and an APB register port.
package bspl_pkg;

   ////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_PER_US = CLK_HZ / 1_000_000;
   localparam int TICK_US = 1000;                   // one millisecond
   localparam int MS_CYCLES = TICK_US * CLK_PER_US;
   localparam int FW_UNIT_US = 5;                   // flash wait unit
   localparam int FW_UNIT_CYCLES = FW_UNIT_US * CLK_PER_US;
   localparam logic [9:0] SLOT_MS = 10'h3e8;        // 1000 ms slot
   localparam logic [1:0] SETTLE_MS = 2'h2;         // sense pin settle
   localparam logic [8:0] SHORT_MS = 9'h001;        // 1 ms events
   localparam logic [8:0] OCV_MS = 9'h0a5;          // 165 ms
   localparam logic [8:0] RESTORE_MS = 9'h1c2;      // 450 ms

   ////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_STEP = 8'h04;
   localparam logic [7:0] OFF_TEMP = 8'h08;
   localparam logic [7:0] OFF_CMD = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;

   // command register bit positions (write-only strobes)
   localparam int CMD_INSERT = 0;
   localparam int CMD_REMOVE = 1;
   localparam int CMD_OCV = 2;
   localparam int CMD_RESTORE = 3;
   localparam int CMD_FLASH = 4;

   ////////////////////////////////////////////////////////////////////
   // register layouts, msb first
   typedef struct packed {
      logic state_change_pulse_en;   // 13
      logic restore_pulse_en;        // 12
      logic overtemp_pulse_en;       // 11
      logic flash_write_pulse_en;    // 10
      logic init_ocv_pulse_en;       // 9
      logic ocv_pulse_en;            // 8
      logic removal_pulse_en;        // 7
      logic low_charge_pulse_en;     // 6
      logic presence_detect_enable;  // 5
      logic [1:0] pin_function_code; // 4:3
      logic good_hold_override;      // 2
      logic event_pulse_polarity;    // 1
      logic good_polarity_sel;       // 0
   } bspl_cfg_type;
   localparam logic [13:0] CFG_RST = 14'h3d28;

   typedef struct packed {
      logic [15:0] flash_write_wait_count; // 23:8
      logic [7:0] charge_step_size;        // 7:0
   } bspl_step_type;
   localparam logic [23:0] STEP_RST = 24'h00000a;

   typedef struct packed {
      logic [7:0] hys;   // 23:16
      logic [7:0] high;  // 15:8
      logic [7:0] low;   // 7:0
   } bspl_temp_type;
   localparam logic [23:0] TEMP_RST = 24'h052d00;

   // gauge-core signals on the same clock
   typedef struct packed {
      logic [6:0] soc;             // state of charge, percent
      logic [1:0] batt_state;      // charge / discharge / relax
      logic [7:0] temp;            // measured battery temperature
      logic low_charge_flag;
      logic shutdown_voltage_flag;
      logic charge_overtemp_flag;
      logic discharge_overtemp_flag;
      logic hibernate;
      logic hib_voltage_only;      // hibernate caused by voltage only
   } bspl_gauge_type;

   typedef enum logic [1:0] {ST_NOBAT, ST_INIT, ST_RUN} bspl_state_type;

endpackage

// File: design/bspl_top.sv
// battery status pin logic: battery-good drive, presence detection
// and the event pulse pin, with an APB register port.
// assumes gauge-core inputs on CLK; sense pin and thermistor-open
// comparator come from outside and are synchronised here.
//
// Contract
// R1 - good held off until initial OCV done
// R2 - good output polarity set by config bit
// R3 - code 1: temperature outside window drops good
// R4 - good returns only inside hysteresis-narrowed window
// R5 - release sense pin before each presence sample
// R6 - sample sense pin each second, low present
// R7 - thermistor near open means battery disconnected
// R8 - host reports presence when detection disabled
// R9 - at most one event pulse per second
// R10 - pulse on charge step point crossings
// R11 - pulse on low-charge flag set or clear
// R12 - always pulse on shutdown flag change; code pulses only in ST_RUN
// R13 - pulse on battery state change if enabled; code also requires a nonzero charge_step_size
// R14 - removal pulse needs removal and detect enables
// R15 - OCV command holds pulse 165 ms
// R16 - initial OCV pulse 165 ms if enabled
// R17 - flash write pulse then programmed wait
// R18 - pulse on first overtemperature flag assertion
// R19 - defaults restore holds pulse 450 ms
// R20 - good active-low by default, high when set
// R21 - event pin active-low by default
// R22 - override keeps good during voltage hibernation
// R23 - millisecond and second ticks from clock
// R24 - merged events take the longest width
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module bspl_top import bspl_pkg::*; #(
   parameter int MS_CYCLES_P = MS_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire bspl_gauge_type GAUGE,
   input wire logic PRESENCE_SENSE_I,
   output logic PRESENCE_SENSE_O,
   output logic PRESENCE_SENSE_OE_N,
   input wire logic THERM_NEAR_OPEN,
   output logic BATTERY_GOOD_OUT,
   output logic EVENT_OUT,
   output logic FLASH_GO
);

   bspl_cfg_type cfg;
   bspl_step_type stp;
   bspl_temp_type lim;
   bspl_state_type state, next_state;
   logic [15:0] ms_div;
   logic [9:0] slot_ms;
   logic ms_tick, sec_tick;
   logic wr, mapped, cmd_wr;
   logic [4:0] cmd;
   logic sense_s1, sense_s2, open_s1, open_s2;
   logic testing, sample_now, present;
   logic [1:0] settle;
   logic [8:0] ocv_ms, pend, ev_ms, req_w;
   logic slot_used, start, ev_act, rem_req, step_req;
   logic soc_edge_req, ocv_req, rst_req;
   logic fw_arm, fw_run, fw_bypass;
   logic [15:0] fw_cnt;
   logic [6:0] fw_sub;
   logic inhibit, next_good, good_q;
   logic [6:0] soc_prev;
   logic [1:0] bs_prev;
   logic lc_prev, sd_prev, ot_prev;
   logic [7:0] d_cur, d_prev;
   logic [8:0] step9;

   ////////////////////////////////////////////////////////////////////
   // millisecond and one-second ticks
   assign ms_tick = ms_div == 16'(MS_CYCLES_P - 1); // R23
   assign sec_tick = ms_tick && slot_ms == SLOT_MS - 10'h001; // R23

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ms_div <= 16'h0000;
         slot_ms <= 10'h000;
      end else begin
         ms_div <= ms_tick ? 16'h0000 : ms_div + 16'h0001;
         if (ms_tick) begin
            slot_ms <= sec_tick ? 10'h000 : slot_ms + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, error on unmapped offsets
   assign wr = PSEL && PENABLE && PWRITE;
   assign mapped = PADDR == OFF_CFG || PADDR == OFF_STEP ||
      PADDR == OFF_TEMP || PADDR == OFF_CMD || PADDR == OFF_STATUS;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign cmd_wr = wr && PADDR == OFF_CMD;
   assign cmd = cmd_wr ? PWDATA[4:0] : 5'h00;

   // configuration writes
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg <= CFG_RST;
         stp <= STEP_RST;
         lim <= TEMP_RST;
      end else if (wr) begin
         if (PADDR == OFF_CFG) cfg <= PWDATA[13:0];
         if (PADDR == OFF_STEP) stp <= PWDATA[23:0];
         if (PADDR == OFF_TEMP) lim <= PWDATA[23:0];
      end
   end

   // read data is latched in the setup cycle so it comes from a flop
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
      end else if (PSEL && !PENABLE) begin
         case (PADDR)
            OFF_CFG: PRDATA <= {18'h00000, cfg};
            OFF_STEP: PRDATA <= {8'h00, stp};
            OFF_TEMP: PRDATA <= {8'h00, lim};
            OFF_STATUS: PRDATA <= {26'h0000000, fw_arm || fw_run,
               ev_act, inhibit, good_q, state == ST_RUN, present};
            default: PRDATA <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // presence detection; pin is held low between tests, released
   // for a short settle time so the pull-up or battery decides it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sense_s1 <= 1'b1;
         sense_s2 <= 1'b1;
         open_s1 <= 1'b0;
         open_s2 <= 1'b0;
      end else begin
         sense_s1 <= PRESENCE_SENSE_I;
         sense_s2 <= sense_s1;
         open_s1 <= THERM_NEAR_OPEN;
         open_s2 <= open_s1;
      end
   end

   assign sample_now = testing && ms_tick && settle == SETTLE_MS - 2'h1;
   assign PRESENCE_SENSE_O = 1'b0;

   // test sequencer, started on each second tick
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         testing <= 1'b0;
         settle <= 2'h0;
         PRESENCE_SENSE_OE_N <= 1'b1;
      end else begin
         if (sec_tick && cfg.presence_detect_enable && !testing) begin
            testing <= 1'b1; // R6
            settle <= 2'h0;
         end else if (sample_now) begin
            testing <= 1'b0;
         end else if (testing && ms_tick) begin
            settle <= settle + 2'h1;
         end
         // released while testing or when detection is off
         PRESENCE_SENSE_OE_N <= !(cfg.presence_detect_enable &&
            !testing && !(sec_tick && !testing)); // R5
      end
   end

   // presence flag from the pin, or from host commands
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         present <= 1'b0;
      end else if (cfg.presence_detect_enable) begin
         if (open_s2) present <= 1'b0; // R7
         else if (sample_now) present <= !sense_s2; // R6
      end else if (cmd[CMD_INSERT]) begin
         present <= 1'b1; // R8
      end else if (cmd[CMD_REMOVE]) begin
         present <= 1'b0; // R8
      end
   end

   ////////////////////////////////////////////////////////////////////
   // insertion sequence: no battery, initial OCV, running
   always_comb begin
      next_state = state;
      case (state)
         ST_NOBAT: if (present) next_state = ST_INIT;
         ST_INIT: begin
            if (!present) next_state = ST_NOBAT;
            else if (ocv_ms == OCV_MS) next_state = ST_RUN; // R1
         end
         ST_RUN: if (!present) next_state = ST_NOBAT;
         default: next_state = ST_NOBAT;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= ST_NOBAT;
         ocv_ms <= 9'h000;
      end else begin
         state <= next_state;
         if (state != ST_INIT) ocv_ms <= 9'h000;
         else if (ms_tick) ocv_ms <= ocv_ms + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // battery-good output and temperature inhibit
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         inhibit <= 1'b0;
      end else if (cfg.pin_function_code != 2'h1) begin
         inhibit <= 1'b0;
      end else if (GAUGE.temp < lim.low || GAUGE.temp > lim.high) begin
         inhibit <= 1'b1; // R3
      end else if (GAUGE.temp >= lim.low + lim.hys &&
                   GAUGE.temp <= lim.high - lim.hys) begin
         inhibit <= 1'b0; // R4
      end
   end

   assign next_good = state == ST_RUN && !inhibit && // R1
      !(GAUGE.hibernate && // R22
        !(cfg.good_hold_override && GAUGE.hib_voltage_only));

   // polarity applied in the same flop stage as the logical level
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         good_q <= 1'b0;
         BATTERY_GOOD_OUT <= 1'b1;
      end else begin
         good_q <= next_good;
         BATTERY_GOOD_OUT <= cfg.good_polarity_sel ? next_good :
            !next_good; // R2 R20
      end
   end

   ////////////////////////////////////////////////////////////////////
   // charge step points counted as depletion from 100 percent
   assign d_cur = 8'h64 - {1'b0, GAUGE.soc};
   assign d_prev = 8'h64 - {1'b0, soc_prev};
   assign step9 = {1'b0, stp.charge_step_size};

   always_comb begin
      step_req = 1'b0;
      if (stp.charge_step_size != 8'h00 && GAUGE.soc > soc_prev) begin
         // charging fires once soc is above a point; 100 is never passed
         step_req = {1'b0, d_cur} / step9 < {1'b0, d_prev} / step9; // R10
      end else if (stp.charge_step_size != 8'h00 &&
                   GAUGE.soc < soc_prev) begin
         step_req = GAUGE.soc == 7'h00 || // R10
            {1'b0, d_cur} / step9 > {1'b0, d_prev} / step9;
      end
   end

   // edge history of the gauge flags
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         soc_prev <= 7'h00;
         bs_prev <= 2'h0;
         lc_prev <= 1'b0;
         sd_prev <= 1'b0;
         ot_prev <= 1'b0;
      end else begin
         soc_prev <= GAUGE.soc;
         bs_prev <= GAUGE.batt_state;
         lc_prev <= GAUGE.low_charge_flag;
         sd_prev <= GAUGE.shutdown_voltage_flag;
         ot_prev <= GAUGE.charge_overtemp_flag ||
            GAUGE.discharge_overtemp_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event requests and their widths
   assign rem_req = state != ST_NOBAT && !present &&
      cfg.removal_pulse_en && cfg.presence_detect_enable; // R14
   assign fw_bypass = !(state == ST_RUN && cfg.flash_write_pulse_en &&
      stp.flash_write_wait_count != 16'h0000); // R17
   assign soc_edge_req = state == ST_RUN && (step_req ||
      (cfg.low_charge_pulse_en &&
       GAUGE.low_charge_flag != lc_prev) || // R11
      GAUGE.shutdown_voltage_flag != sd_prev || // R12
      (stp.charge_step_size != 8'h00 && cfg.state_change_pulse_en &&
       GAUGE.batt_state != bs_prev) || // R13
      (cfg.overtemp_pulse_en && !ot_prev &&
       (GAUGE.charge_overtemp_flag ||
        GAUGE.discharge_overtemp_flag)) || // R18
      (cmd[CMD_FLASH] && !fw_bypass)); // R17
   assign ocv_req = state == ST_RUN && cmd[CMD_OCV] &&
      cfg.ocv_pulse_en; // R15
   assign rst_req = cmd[CMD_RESTORE] && cfg.restore_pulse_en; // R19

   // widest request wins, later lines override earlier ones
   always_comb begin
      req_w = 9'h000;
      if (soc_edge_req || rem_req) req_w = SHORT_MS;
      if (ocv_req) req_w = OCV_MS; // R15
      if (rst_req) req_w = RESTORE_MS; // R19
   end

   assign start = pend != 9'h000 && ev_ms == 9'h000 && !slot_used;
   assign ev_act = ev_ms != 9'h000 ||
      (state == ST_INIT && cfg.init_ocv_pulse_en); // R16

   // pending width merges events; a request in the issuing cycle is
   // kept for the next slot rather than lost
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pend <= 9'h000;
         ev_ms <= 9'h000;
         slot_used <= 1'b0;
      end else begin
         if (start) pend <= req_w;
         else if (req_w > pend) pend <= req_w; // R24
         // one extra tick so a pulse never runs short of its width
         if (start) ev_ms <= pend + 9'h001;
         else if (ms_tick && ev_ms != 9'h000) ev_ms <= ev_ms - 9'h001;
         if (start) slot_used <= 1'b1; // R9
         else if (sec_tick) slot_used <= 1'b0; // R9
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         EVENT_OUT <= 1'b1;
      end else begin
         EVENT_OUT <= cfg.event_pulse_polarity ? ev_act : !ev_act; // R21
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flash update: wait count times 5 us after the pulse is issued
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fw_arm <= 1'b0;
         fw_run <= 1'b0;
         fw_cnt <= 16'h0000;
         fw_sub <= 7'h00;
         FLASH_GO <= 1'b0;
      end else begin
         FLASH_GO <= 1'b0;
         if (cmd[CMD_FLASH] && fw_bypass) begin
            FLASH_GO <= 1'b1;
         end else if (cmd[CMD_FLASH]) begin
            fw_arm <= 1'b1;
         end else if (fw_arm && start) begin
            fw_arm <= 1'b0;
            fw_run <= 1'b1; // R17
            fw_cnt <= stp.flash_write_wait_count;
            fw_sub <= 7'h00;
         end else if (fw_run) begin
            if (fw_sub == 7'(FW_UNIT_CYCLES - 1)) begin
               fw_sub <= 7'h00;
               fw_cnt <= fw_cnt - 16'h0001;
               if (fw_cnt == 16'h0001) begin
                  fw_run <= 1'b0;
                  FLASH_GO <= 1'b1; // R17
               end
            end else begin
               fw_sub <= fw_sub + 7'h01;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   logic [1:0] starts_in_slot;
   logic pol_g;
   assign pol_g = cfg.good_polarity_sel;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) starts_in_slot <= 2'h0;
      else if (sec_tick) starts_in_slot <= 2'h0;
      else if (start && starts_in_slot != 2'h3)
         starts_in_slot <= starts_in_slot + 2'h1;
   end

   a_good_waits_ocv: assert property ( // R1
      state != ST_RUN |=> !good_q)
      else $error("battery good raised before initial OCV");
   a_good_pol_map: assert property ( // R2
      ##1 BATTERY_GOOD_OUT == ($past(pol_g) ? good_q : !good_q))
      else $error("battery good pin polarity wrong");
   a_temp_inhibit: assert property ( // R3
      cfg.pin_function_code == 2'h1 &&
      (GAUGE.temp < lim.low || GAUGE.temp > lim.high) |=> ##1 !good_q)
      else $error("good stays on out of temperature window");
   a_hys_hold: assert property ( // R4
      inhibit && cfg.pin_function_code == 2'h1 &&
      GAUGE.temp >= lim.low && GAUGE.temp <= lim.high &&
      (GAUGE.temp < lim.low + lim.hys || GAUGE.temp > lim.high - lim.hys)
      |=> inhibit)
      else $error("inhibit cleared inside hysteresis band");
   a_pin_released: assert property ( // R5
      sample_now |-> PRESENCE_SENSE_OE_N && $past(PRESENCE_SENSE_OE_N))
      else $error("sense pin driven while sampled");
   a_one_per_slot: assert property ( // R9
      starts_in_slot <= 2'h1)
      else $error("two event pulses in one slot");
   a_merge_width: assert property ( // R24
      !start && req_w > pend |=> pend == $past(req_w))
      else $error("merged width is not the longest");
   a_removal_gate: assert property ( // R14
      !cfg.presence_detect_enable |-> !rem_req)
      else $error("removal pulse without presence detection");
   a_init_pulse: assert property ( // R16
      state == ST_INIT && cfg.init_ocv_pulse_en &&
      !cfg.event_pulse_polarity |=> !EVENT_OUT)
      else $error("initial OCV pulse missing");
   a_flash_wait: assert property ( // R17
      fw_run && fw_cnt > 16'h0001 |=> !FLASH_GO)
      else $error("flash update started before wait ended");

   c_restore_pulse: cover property (start && pend == RESTORE_MS);
   c_flash_go: cover property (fw_run ##1 FLASH_GO);
   c_init_done: cover property (state == ST_INIT ##1 state == ST_RUN);

endmodule

// File: dv/bspl_batt_model.sv
// battery and pull-up model at the presence sense pin, plus the
// thermistor-open comparator level.
// assumes the device releases the pin with a high output enable.
`timescale 1ns/1ps
module bspl_batt_model (
   input wire logic sense_o,
   input wire logic sense_oe_n,
   input wire logic batt_in,
   input wire logic open_in,
   output logic sense_i,
   output logic therm_open
);
   ////////////////////////////////////////////////////////////////////
   // device drive wins; released pin is pulled low by a battery,
   // otherwise the weak pull-up holds it high
   assign sense_i = !sense_oe_n ? sense_o : !batt_in;
   // comparator reads high once the thermistor looks open
   assign therm_open = open_in;
endmodule

// File: dv/bspl_tb_top.sv
// testbench for the battery status pin logic: apb sequences and
// pin timing against widths worked out from the tick length.
// assumes the battery model at the sense pin; ms tick shortened.
`timescale 1ns/1ps
module bspl_tb_top import bspl_pkg::*; ;
   localparam int M = 8;
   localparam int SEC = 1000 * M;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, sense_i, sense_o, oe_n, therm, good, ev, fgo;
   logic batt = 1, open_th = 0;
   logic [3:0] pins;
   bspl_gauge_type g = '0;
   int miscompares = 0, samples_checked = 0, n1, n2, t0, cyc = 0;

   // 25 MHz clock and a free cycle count
   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   assign pins = {fgo, oe_n, good, ev};

   bspl_top #(.MS_CYCLES_P(M)) uut (.CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GAUGE(g),
      .PRESENCE_SENSE_I(sense_i), .PRESENCE_SENSE_O(sense_o),
      .PRESENCE_SENSE_OE_N(oe_n), .THERM_NEAR_OPEN(therm),
      .BATTERY_GOOD_OUT(good), .EVENT_OUT(ev), .FLASH_GO(fgo));
   bspl_batt_model batt_m (.sense_o(sense_o), .sense_oe_n(oe_n),
      .batt_in(batt), .open_in(open_th), .sense_i(sense_i),
      .therm_open(therm));

   ////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         chk(32'(pready), 32'h1);
         finish_test;
      end
   endtask

   // bounded wait on one pin; running out is a mismatch and ends the run
   task wt(input int s, input logic v, input int lim, output int n);
      n = 0;
      while (pins[s] !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(32'(pins[s]), 32'(v));
      if (pins[s] !== v) finish_test;
   endtask

   // waits for an event pulse, then checks a width of w to w+1 ms
   task pulse(input int lim, input int w, output int n);
      int k;
      wt(0, 1'b0, lim, n);
      wt(0, 1'b1, (w + 2) * M, k);
      chk(32'(k >= w * M && k <= (w + 1) * M + 2), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      g.soc = 7'h32;
      g.temp = 8'h19;
      repeat (4) @(posedge clk);
      chk(32'({good, ev, oe_n, sense_o}), 32'he);
      rst <= 1'b0;
      apb(0, OFF_CFG, 0);
      chk(q, 32'h3d28);
      apb(0, OFF_STEP, 0);
      chk(q, 32'h0000000a);
      apb(0, OFF_TEMP, 0);
      chk(q, 32'h00052d00);
      apb(0, 8'h14, 0);
      chk({q[30:0], err}, 32'h1);
      // presence test, initial ocv, then the next test a second later
      wt(2, 1'b1, SEC + 10, n1);
      t0 = cyc;
      wt(2, 1'b0, 4 * M, n1);
      chk(32'(n1 >= 2 * M), 32'h1);
      apb(0, OFF_STATUS, 0);
      chk(32'({q[0], good}), 32'h3);
      wt(1, 1'b0, 170 * M, n2);
      chk(32'(n2 >= 163 * M), 32'h1);
      wt(2, 1'b1, SEC, n1);
      chk(cyc - t0, SEC);
      // shutdown pulse, then two events merged into the next slot
      @(posedge clk) g.shutdown_voltage_flag <= 1'b1;
      pulse(4 * M, 1, n1);
      @(posedge clk) g.batt_state <= 2'h1;
      apb(1, OFF_CMD, 32'h4);
      pulse(SEC + 10, 165, n1);
      chk(32'(n1 > 900 * M), 32'h1);
      // charge inhibit window and its hysteresis
      @(posedge clk) g.temp <= 8'h32;
      wt(1, 1'b1, 2 * M, n1);
      @(posedge clk) g.temp <= 8'h2a;
      repeat (3 * M) @(negedge clk);
      chk(32'(good), 32'h1);
      @(posedge clk) g.temp <= 8'h1e;
      wt(1, 1'b0, 2 * M, n1);
      // voltage-only hibernation drops good unless the override is set
      @(posedge clk) {g.hibernate, g.hib_voltage_only} <= 2'h3;
      wt(1, 1'b1, 2 * M, n1);
      apb(1, OFF_CFG, 32'h3d2c);
      wt(1, 1'b0, 2 * M, n1);
      @(posedge clk) g.hibernate <= 1'b0;
      // both pins turned to active high, then back
      apb(1, OFF_CFG, 32'h3d2b);
      repeat (4) @(negedge clk);
      chk(32'({good, ev}), 32'h2);
      apb(1, OFF_CFG, 32'h3d28);
      // flash request: pulse, then a wait of count times 5 us
      apb(1, OFF_STEP, 32'h0000040a);
      apb(1, OFF_CMD, 32'h10);
      wt(0, 1'b0, SEC + 10, n1);
      wt(3, 1'b1, 600, n2);
      chk(32'(n2 >= 4 * FW_UNIT_CYCLES - 3), 32'h1);
      chk(32'(n2 <= 4 * FW_UNIT_CYCLES + 2), 32'h1);
      apb(1, OFF_CMD, 32'h8);
      pulse(SEC + 10, 450, n1);
      // soc climbs past the 50 percent point, then an overtemp flag
      @(posedge clk) g.soc <= 7'h33;
      pulse(SEC + 10, 1, n1);
      @(posedge clk) g.charge_overtemp_flag <= 1'b1;
      pulse(SEC + 10, 1, n1);
      // thermistor open drops presence and good; removal pulse enabled
      apb(1, OFF_CFG, 32'h3da8);
      @(posedge clk) open_th <= 1'b1;
      wt(1, 1'b1, 8, n1);
      pulse(SEC + 10, 1, n1);
      apb(0, OFF_STATUS, 0);
      chk(32'(q[0]), 32'h0);
      // detection off: host reports insert and removal; the insert
      // shows the initial ocv pulse, the removal must stay silent
      apb(1, OFF_CFG, 32'h3f88);
      open_th <= 1'b0;
      apb(1, OFF_CMD, 32'h1);
      apb(0, OFF_STATUS, 0);
      chk(32'({q[0], ev}), 32'h2);
      apb(1, OFF_CMD, 32'h2);
      apb(0, OFF_STATUS, 0);
      chk(32'(q[0]), 32'h0);
      n2 = 0;
      repeat (SEC + 10) @(negedge clk) if (!ev) n2++;
      chk(n2, 0);
      finish_test;
   end
endmodule
